// [core/pmc_framer.sv]
// particle monitor can message framer and command decoder
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"
module pmc_framer #(
    parameter int HB_CYCLES = `PMC_HB_CYCLES,
    parameter int DUR_W = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [28:0] base_addr,
    input wire logic id_ext,
    input wire logic [DUR_W-1:0] test_time_s,
    input wire logic moist_fitted,
    input wire logic test_done,
    input wire logic [7:0][31:0] cum_count,
    input wire logic [5:0][3:0] class_code,
    input wire logic [7:0] status_code,
    input wire logic [5:0] alarm_flags,
    input wire logic modbus_remote,
    input wire logic start_in,
    input wire logic [1:0] relay_state,
    input wire logic [7:0] relative_humidity_percent,
    input wire logic [7:0] temp_c,
    input wire logic rx_valid,
    input wire pmc_pkg::pmc_frame_s rx_frame,
    output logic tx_valid,
    input wire logic tx_ready,
    output pmc_pkg::pmc_frame_s tx_frame,
    output logic test_start,
    output logic test_stop,
    output logic test_running,
    output pmc_pkg::pmc_fmt_e result_format,
    output logic [31:0] test_number
);
    // ***************************
    // parameter checks
    // ***************************
    generate
        if (HB_CYCLES < 2 || DUR_W < 1 || DUR_W > 24) begin : g_bad
            $error("pmc_framer: unsupported parameter values");
        end
    endgenerate

    // ***************************
    // identifiers
    // ***************************
    logic [28:0] id_result;
    logic [28:0] id_status;
    logic [28:0] id_moist;
    logic [28:0] id_cmd_ext;
    logic [28:0] id_cmd_std;

    // every id but the extended command id is an offset from the one base value
    assign id_result = base_addr;
    assign id_status = base_addr + (id_ext ? `PMC_EXT_STEP : `PMC_STD_STEP);
    assign id_moist = id_status + (id_ext ? `PMC_EXT_STEP : `PMC_STD_STEP);
    assign id_cmd_ext = {base_addr[28:24], `PMC_EXT_CMD_PF, base_addr[7:0], `PMC_EXT_CMD_SRC};
    assign id_cmd_std = base_addr + `PMC_STD_CMD_OFS;

    // ***************************
    // command decode
    // ***************************
    logic cmd_hit;
    logic [7:0] cmd_fn;
    logic [31:0] cmd_param;
    logic fn_start;
    logic fn_start_num;
    logic fn_stop;
    logic fn_fmt;

    // both network styles land on the same decoder
    assign cmd_hit = rx_valid && (rx_frame.id == (id_ext ? id_cmd_ext : id_cmd_std))
        && (rx_frame.dlc >= `PMC_CMD_MIN_DLC) && (rx_frame.data[7:0] == `PMC_CMD_BYTE);
    assign cmd_fn = rx_frame.data[15:8];
    assign cmd_param = rx_frame.data[47:16];
    assign fn_start = cmd_hit && (cmd_fn == `PMC_FN_START);
    assign fn_start_num = cmd_hit && (cmd_fn == `PMC_FN_START_NUM);
    assign fn_stop = cmd_hit && (cmd_fn == `PMC_FN_STOP);
    assign fn_fmt = cmd_hit && (cmd_fn >= `PMC_FN_FMT_ISO) && (cmd_fn <= `PMC_FN_FMT_I11218);

    // format select; unknown functions leave it alone
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result_format <= pmc_pkg::PMC_FMT_ISO;
        end else if (fn_fmt) begin
            result_format <= pmc_pkg::pmc_fmt_e'(3'(cmd_fn - `PMC_FN_FMT_ISO));
        end
    end

    // start and stop strobes toward the measurement core
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            test_start <= 1'b0;
            test_stop <= 1'b0;
        end else begin
            test_start <= fn_start || fn_start_num;
            test_stop <= fn_stop;
        end
    end

    // running flag: a stop or a finished test ends it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            test_running <= 1'b0;
        end else if (fn_start || fn_start_num) begin
            test_running <= 1'b1;
        end else if (fn_stop || test_done) begin
            test_running <= 1'b0;
        end
    end

    // test number: loaded, bumped per commanded start, or per free-running test
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            test_number <= 32'h0000_0000;
        end else if (fn_start_num) begin
            test_number <= cmd_param;
        end else if (fn_start || (test_done && !test_running)) begin
            test_number <= test_number + 32'h0000_0001;
        end
    end

    // ***************************
    // heartbeat and completion
    // ***************************
    logic [31:0] hb_cnt_r;
    logic tick;
    logic [DUR_W:0] acc_r;
    logic [7:0] pct_r;

    assign tick = (hb_cnt_r == 32'(HB_CYCLES - 1));

    // one second divider
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hb_cnt_r <= 32'h0000_0000;
        end else if (tick) begin
            hb_cnt_r <= 32'h0000_0000;
        end else begin
            hb_cnt_r <= hb_cnt_r + 32'h0000_0001;
        end
    end

    // percent by subtracting the duration per clock, no divider needed
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_r <= '0;
            pct_r <= 8'h00;
        end else if (fn_start || fn_start_num) begin
            acc_r <= '0;
            pct_r <= 8'h00;
        end else if (test_done) begin
            pct_r <= `PMC_PCT_FULL;
        end else if (test_running && pct_r != `PMC_PCT_FULL) begin
            if (test_time_s == '0) begin
                pct_r <= `PMC_PCT_FULL;
            end else if (acc_r >= {1'b0, test_time_s}) begin
                acc_r <= acc_r - {1'b0, test_time_s};
                pct_r <= pct_r + 8'h01;
            end else if (tick) begin
                acc_r <= acc_r + (DUR_W+1)'(`PMC_PCT_FULL);
            end
        end
    end

    // ***************************
    // result bytes
    // ***************************
    // scale upper limits in particles per 100 ml so that 0.01/ml becomes 1
    localparam logic [31:0] ISO_LIM [0:28] = '{
        32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0008,
        32'h0000_0010, 32'h0000_0020, 32'h0000_0040, 32'h0000_0082,
        32'h0000_00FA, 32'h0000_01F4, 32'h0000_03E8, 32'h0000_07D0,
        32'h0000_0FA0, 32'h0000_1F40, 32'h0000_3E80, 32'h0000_7D00,
        32'h0000_FA00, 32'h0001_FBD0, 32'h0003_D090, 32'h0007_A120,
        32'h000F_4240, 32'h001E_8480, 32'h003D_0900, 32'h007A_1200,
        32'h00F4_2400, 32'h01E8_4800, 32'h03D0_9000, 32'h07BF_A480,
        32'h0EE6_B280
    };

    // smallest scale whose limit holds the count, else the over-range code
    function automatic logic [7:0] iso_scale(input logic [31:0] cnt);
        logic [7:0] code;
        code = `PMC_ISO_OVER;
        for (int s = 28; s >= 0; s--) begin
            if (cnt <= ISO_LIM[s]) begin
                code = 8'(s);
            end
        end
        return code;
    endfunction

    logic [7:0][7:0] iso_bytes;
    logic [5:0][7:0] cls_bytes;
    logic [3:0] max5;
    logic [3:0] max6;
    logic [63:0] res_data;

    // one scale and one signed class per band
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_iso
            assign iso_bytes[gi] = iso_scale(cum_count[gi]);
        end
        for (gi = 0; gi < 6; gi++) begin : g_cls
            // code 0 is triple-zero, so subtracting two gives 0xFE, 0xFF, 0..
            assign cls_bytes[gi] = {4'h0, class_code[gi]} - `PMC_CLASS_OFS;
        end
    endgenerate

    // overall class over the bands that the format uses
    always_comb begin
        max5 = class_code[0];
        for (int b = 1; b < 5; b++) begin
            if (class_code[b] > max5) begin
                max5 = class_code[b];
            end
        end
        max6 = (class_code[5] > max5) ? class_code[5] : max5;
    end

    // byte one sits in the low bits of the data word
    always_comb begin
        unique case (result_format)
            pmc_pkg::PMC_FMT_ISO: begin
                res_data = iso_bytes;
            end
            pmc_pkg::PMC_FMT_E2: begin
                res_data = {cls_bytes, 8'h00, ({4'h0, max6} - `PMC_CLASS_OFS)};
            end
            pmc_pkg::PMC_FMT_NAS, pmc_pkg::PMC_FMT_E1, pmc_pkg::PMC_FMT_I11218: begin
                res_data = {8'h00, cls_bytes[4:0], 8'h00, ({4'h0, max5} - `PMC_CLASS_OFS)};
            end
            default: begin
                res_data = 64'h0000_0000_0000_0000;
            end
        endcase
    end

    // result frame is frozen at the end of the test
    logic [63:0] res_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            res_r <= 64'h0000_0000_0000_0000;
        end else if (test_done) begin
            res_r <= res_data;
        end
    end

    // ***************************
    // status flags
    // ***************************
    logic have_result_r;
    logic upd_toggle_r;
    logic new_result_r;
    logic tested_r;
    logic traffic_r;
    logic [15:0] flags;
    logic load_status;

    // result flags; a new result beats the clear after a status send
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            have_result_r <= 1'b0;
            upd_toggle_r <= 1'b0;
            new_result_r <= 1'b0;
            tested_r <= 1'b0;
        end else begin
            if (test_done) begin
                have_result_r <= 1'b1;
                upd_toggle_r <= ~upd_toggle_r;
                tested_r <= 1'b1;
            end
            if (test_done) begin
                new_result_r <= 1'b1;
            end else if (load_status) begin
                new_result_r <= 1'b0;
            end
        end
    end

    // any frame seen on the bus unlocks transmission
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            traffic_r <= 1'b0;
        end else if (rx_valid) begin
            traffic_r <= 1'b1;
        end
    end

    assign flags = {1'b0, relay_state, start_in,
        modbus_remote,
        alarm_flags,
        tested_r && !test_running, test_running,
        new_result_r, upd_toggle_r, have_result_r};

    // ***************************
    // frame scheduling
    // ***************************
    logic res_pend_r;
    logic stat_pend_r;
    logic moist_pend_r;
    logic may_send;
    logic buf_ready;
    logic load_res;
    logic load_moist;
    pmc_pkg::pmc_frame_s nxt_frame;

    assign may_send = tested_r || traffic_r;
    assign load_res = may_send && buf_ready && res_pend_r;
    assign load_status = may_send && buf_ready && !res_pend_r && stat_pend_r;
    assign load_moist = may_send && buf_ready && !res_pend_r && !stat_pend_r && moist_pend_r;

    // pending requests; a new request in the load cycle is kept
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            res_pend_r <= 1'b0;
            stat_pend_r <= 1'b0;
            moist_pend_r <= 1'b0;
        end else begin
            if (test_done) begin
                res_pend_r <= 1'b1;
            end else if (load_res) begin
                res_pend_r <= 1'b0;
            end
            if (tick) begin
                stat_pend_r <= 1'b1;
            end else if (load_status) begin
                stat_pend_r <= 1'b0;
            end
            if (tick && moist_fitted) begin
                moist_pend_r <= 1'b1;
            end else if (load_moist) begin
                moist_pend_r <= 1'b0;
            end
        end
    end

    // frame contents, little-endian fields
    always_comb begin
        nxt_frame.id = id_moist;
        nxt_frame.dlc = `PMC_DLC_MOIST;
        nxt_frame.data = {48'h0000_0000_0000, temp_c, relative_humidity_percent};
        if (res_pend_r) begin
            nxt_frame.id = id_result;
            nxt_frame.dlc = `PMC_DLC_FULL;
            nxt_frame.data = res_r;
        end else if (stat_pend_r) begin
            nxt_frame.id = id_status;
            nxt_frame.dlc = `PMC_DLC_FULL;
            nxt_frame.data = {flags, pct_r, status_code, test_number};
        end
    end

    // buffer keeps a frame safe while the controller is busy
    pmc_skid #(
        .W($bits(pmc_pkg::pmc_frame_s))
    ) u_buf (
        .clk(clk),
        .resetn(resetn),
        .in_valid(load_res || load_status || load_moist),
        .in_ready(buf_ready),
        .in_data(nxt_frame),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_frame)
    );
endmodule
`default_nettype wire

// [core/pmc_map.svh]
// constants of the particle monitor message framer: ids, fields, timing
// Behaviour
// - one result frame of eight bytes after each test
// - result bytes follow the selected format
// - iso bytes one to eight code the 4..70 micrometre bands
// - class formats: maximum class in byte one, byte two unused
// - double-zero sent as 0xFF, triple-zero as 0xFE
// - status frame once per second as heartbeat
// - silent before first test until bus traffic seen
// - status bytes 1-4: test number, incremented or loaded
// - status byte 5: state or fault code
// - status byte 6: completion 0 to 100
// - flag bits 0-2: result availability and update
// - flag bits 3-4: test progress
// - flag bits 5-10: alarm conditions
// - flag bit 11: remote modbus control
// - flag bits 12-14: start input and alarm relays
// - moisture frame: humidity unsigned, temperature signed
// - commands as peer-to-peer or canopen receive frames
// - command: byte 0x00, function, 32-bit parameter in bytes 3-6
// - function 1 starts, 9 stops, 13 starts with fixed number
// - functions 14-18 select iso, nas, table2, table1, iso11218
// - iso scale from cumulative counts, above 28 sent as 29
// - multi-byte fields least significant byte first
// - all ids derive from the base address
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ***************************
// frame layout
// ***************************
`define PMC_DLC_FULL 4'h8
`define PMC_DLC_MOIST 4'h2
`define PMC_CMD_MIN_DLC 4'h6
`define PMC_CMD_BYTE 8'h00

// ***************************
// identifier derivation
// ***************************
`define PMC_EXT_STEP 29'h0000100
`define PMC_STD_STEP 29'h0000100
`define PMC_STD_CMD_OFS 29'h0000080
`define PMC_EXT_CMD_PF 8'hEF
`define PMC_EXT_CMD_SRC 8'h00

// ***************************
// command functions
// ***************************
`define PMC_FN_START 8'h01
`define PMC_FN_STOP 8'h09
`define PMC_FN_START_NUM 8'h0D
`define PMC_FN_FMT_ISO 8'h0E
`define PMC_FN_FMT_NAS 8'h0F
`define PMC_FN_FMT_E2 8'h10
`define PMC_FN_FMT_E1 8'h11
`define PMC_FN_FMT_I11218 8'h12

// ***************************
// result coding
// ***************************
`define PMC_CLASS_OFS 8'h02
`define PMC_ISO_OVER 8'h1D
`define PMC_PCT_FULL 8'h64

// ***************************
// timing
// ***************************
`define PMC_CLK_MHZ 200
`define PMC_HB_PERIOD_MS 1000
`define PMC_HB_CYCLES (`PMC_HB_PERIOD_MS * `PMC_CLK_MHZ * 1000)

`endif

// [core/pmc_pkg.sv]
// types shared by the particle monitor message framer
package pmc_pkg;

    // result formats selectable by command
    typedef enum logic [2:0] {
        PMC_FMT_ISO = 3'b000,
        PMC_FMT_NAS = 3'b001,
        PMC_FMT_E2 = 3'b010,
        PMC_FMT_E1 = 3'b011,
        PMC_FMT_I11218 = 3'b100
    } pmc_fmt_e;

    // one can frame, data byte one in bits 7:0
    typedef struct packed {
        logic [28:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
    } pmc_frame_s;

endpackage

// [core/pmc_skid.sv]
// two-entry frame buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pmc_skid #(
    parameter int W = 97
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_r [0:1];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    logic push;
    logic pop;

    // flags straight from the count
    assign push = in_valid && (cnt_r != 2'h2);
    assign pop = (cnt_r != 2'h0) && out_ready;
    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rp_r];

    // storage, no reset needed for the words
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// [tb/pmc_framer_monitor.sv]
// assertion checker watching the ports of the particle monitor framer
`timescale 1ns/1ps
`default_nettype none
module pmc_framer_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [28:0] base_addr,
    input wire logic id_ext,
    input wire logic test_done,
    input wire logic rx_valid,
    input wire pmc_pkg::pmc_frame_s rx_frame,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire pmc_pkg::pmc_frame_s tx_frame,
    input wire logic test_start,
    input wire logic test_stop,
    input wire logic test_running,
    input wire pmc_pkg::pmc_fmt_e result_format,
    input wire logic [31:0] test_number
);
    // ***********************
    // helper logic
    // ***********************
    logic seen_r;
    logic [28:0] cmd_id;
    logic [7:0] fn;
    logic [7:0] fmt_idx;
    logic cmd_ok;
    // command id differs per id style, so decode it here once
    assign cmd_id = id_ext ? {base_addr[28:24], 8'hEF, base_addr[7:0], 8'h00}
                           : base_addr + 29'h0000080;
    assign fn = rx_frame.data[15:8];
    assign fmt_idx = fn - 8'h0E;
    assign cmd_ok = rx_valid && rx_frame.id == cmd_id && rx_frame.dlc >= 4'h6
                    && rx_frame.data[7:0] == 8'h00;
    // any frame or finished test lifts the start-up silence
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seen_r <= 1'b0;
        end else if (rx_valid || test_done) begin
            seen_r <= 1'b1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // ***********************
    // assertions
    // ***********************
    a_tx_held_stall: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
        else $error("stalled frame changed");
    a_silent_startup: assert property (
        !seen_r |-> !tx_valid)
        else $error("early frame");
    a_result_len_eight: assert property (
        tx_valid && tx_frame.id == base_addr |-> tx_frame.dlc == 4'h8)
        else $error("result dlc");
    a_class_byte_two: assert property (
        tx_valid && tx_frame.id == base_addr && result_format != pmc_pkg::PMC_FMT_ISO
        |-> tx_frame.data[15:8] == 8'h00)
        else $error("class byte two");
    a_start_cmd_run: assert property (
        cmd_ok && fn == 8'h01 |=> test_start && test_running)
        else $error("start ignored");
    a_fixed_num_load: assert property (
        cmd_ok && fn == 8'h0D |=> test_start && test_number == $past(rx_frame.data[47:16]))
        else $error("number not loaded");
    a_stop_cmd_halt: assert property (
        cmd_ok && fn == 8'h09 |=> test_stop && !test_running)
        else $error("stop ignored");
    a_format_select: assert property (
        cmd_ok && fn >= 8'h0E && fn <= 8'h12
        |=> result_format == pmc_pkg::pmc_fmt_e'($past(fmt_idx[2:0])))
        else $error("format not set");
    a_bad_cmd_ignored: assert property (
        rx_valid && rx_frame.data[7:0] != 8'h00 && !test_done
        |=> !test_start && !test_stop && $stable(result_format) && $stable(test_number))
        else $error("bad command acted");
    // main scenarios reached
    c_result_sent: cover property (tx_valid && tx_ready && tx_frame.id == base_addr);
    c_stalled: cover property (tx_valid && !tx_ready [*3]);
    c_fixed_start: cover property (cmd_ok && fn == 8'h0D);
endmodule
bind pmc_framer pmc_framer_monitor i_mon (.*);
`default_nettype wire

// [tb/pmc_can_node.sv]
// behavioural can network node facing the framer
`timescale 1ns/1ps
`default_nettype none
module pmc_can_node (
    input wire logic clk,
    input wire logic [1:0] stall,
    input wire logic tx_valid,
    input wire pmc_pkg::pmc_frame_s tx_frame,
    output logic tx_ready,
    output logic rx_valid,
    output pmc_pkg::pmc_frame_s rx_frame
);
    pmc_pkg::pmc_frame_s got[$];
    logic phase;
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_frame = '0;
        phase = 1'b0;
    end
    // stall 0 prompt, 1 every other cycle, 2 refuse all
    always @(negedge clk) begin
        phase <= ~phase;
        tx_ready <= (stall == 2'h0) || (stall == 2'h1 && phase);
    end
    // every accepted frame is queued for the bench
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_frame);
        end
    end
    // shortest command frame
    task automatic send(input logic [28:0] id, input logic [7:0] cb, input logic [7:0] fn,
                        input logic [31:0] prm);
        @(negedge clk);
        rx_frame <= '{id: id, dlc: 4'h6, data: {16'h0000, prm, fn, cb}};
        rx_valid <= 1'b1;
        @(negedge clk);
        rx_valid <= 1'b0;
        rx_frame <= ~rx_frame; // released bus shows no stale frame
    endtask
endmodule
`default_nettype wire

// [tb/test_pmc_framer.sv]
// self-checking bench of the particle monitor message framer
`timescale 1ns/1ps
`default_nettype none
module test_pmc_framer;
    localparam int HB = 300;
    localparam logic [28:0] BASE = 29'h18FFB53F;
    localparam logic [28:0] CMD = 29'h18EF3F00;
    logic clk, resetn, id_ext, test_done, modbus_remote, start_in, rx_valid, tx_valid, tx_ready;
    logic test_start, test_stop, test_running;
    logic [28:0] base_addr;
    logic [15:0] test_time_s;
    logic [7:0][31:0] cum_count;
    logic [5:0][3:0] class_code;
    logic [7:0] status_code, rh_pct, temp_c;
    logic [5:0] alarm_flags;
    logic [1:0] relay_state, stall;
    logic [31:0] test_number;
    pmc_pkg::pmc_frame_s rx_frame, tx_frame, fr;
    pmc_pkg::pmc_fmt_e result_format;
    int n_errors, compares;
    logic [63:0] exp_res [2];
    pmc_framer #(.HB_CYCLES(HB), .DUR_W(16)) i_dut (.clk(clk), .resetn(resetn),
        .base_addr(base_addr), .id_ext(id_ext), .test_time_s(test_time_s),
        .moist_fitted(1'b1), .test_done(test_done), .cum_count(cum_count),
        .class_code(class_code), .status_code(status_code), .alarm_flags(alarm_flags),
        .modbus_remote(modbus_remote), .start_in(start_in), .relay_state(relay_state),
        .relative_humidity_percent(rh_pct), .temp_c(temp_c), .rx_valid(rx_valid),
        .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_frame(tx_frame), .test_start(test_start), .test_stop(test_stop),
        .test_running(test_running), .result_format(result_format),
        .test_number(test_number));
    pmc_can_node i_node (.clk(clk), .stall(stall), .tx_valid(tx_valid),
        .tx_frame(tx_frame), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_frame(rx_frame));
    always #2.5 clk = ~clk;
    // ***********************
    // shared tasks
    // ***********************
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // pop until this id
    task automatic get(input logic [28:0] id);
        int k;
        k = 0;
        while (k < 3000) begin
            if (i_node.got.size() > 0) begin
                fr = i_node.got.pop_front();
                if (fr.id === id) return;
            end else begin
                @(negedge clk);
                k++;
            end
        end
        chk("frame id", 64'h0, {35'h0, id});
    endtask
    task automatic pulse_done();
        @(negedge clk);
        test_done = 1'b1;
        @(negedge clk);
        test_done = 1'b0;
    endtask
    task automatic end_sim();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ***********************
    // scenarios
    // ***********************
    task automatic t_silent();
        repeat (2 * HB + 50) @(negedge clk);
        chk("silent frames", 64'(i_node.got.size()), 64'h0);
        chk("silent valid", tx_valid, 64'h0);
        $display("done silent start-up");
    endtask
    task automatic t_commands();
        i_node.send(CMD, 8'h00, 8'h0D, 32'h12345678);
        chk("fixed start", test_start, 64'h1);
        chk("fixed number", test_number, 64'h12345678);
        i_node.send(CMD, 8'h00, 8'h01, 32'h0);
        chk("start run", test_running, 64'h1);
        chk("auto number", test_number, 64'h12345679);
        i_node.send(CMD, 8'h01, 8'h09, 32'h0);
        chk("bad byte stop", test_stop, 64'h0);
        i_node.send(CMD, 8'h00, 8'h05, 32'h1);
        chk("bad fn number", test_number, 64'h12345679);
        i_node.send(BASE + 29'h100, 8'h00, 8'h09, 32'h0);
        chk("wrong id run", test_running, 64'h1);
        repeat (HB + 20) @(negedge clk);
        i_node.got.delete();
        get(BASE + 29'h100);
        chk("status len", fr.dlc, 64'h8);
        chk("status number", fr.data[31:0], 64'h12345679);
        chk("status code", fr.data[39:32], 64'h5A);
        chk("status pct", fr.data[47:40], 64'h0);
        chk("status flags", fr.data[63:48], {48'h0, 1'b0, relay_state, start_in, modbus_remote,
            alarm_flags, 5'b01000});
        get(BASE + 29'h200);
        chk("moist len", fr.dlc, 64'h2);
        chk("moist bytes", fr.data[15:0], 64'h0000F637);
        $display("done commands and status");
    endtask
    task automatic t_iso();
        stall = 2'h2;
        cum_count = {32'd250000001, 32'd250000000, 32'd16, 32'd8, 32'd4, 32'd2, 32'd1, 32'd0};
        pulse_done();
        repeat (HB + 50) @(negedge clk);
        chk("held valid", tx_valid, 64'h1);
        stall = 2'h1;
        get(BASE);
        chk("iso len", fr.dlc, 64'h8);
        chk("iso bytes", fr.data, 64'h1D1C040302010000);
        get(BASE + 29'h100);
        chk("done pct", fr.data[47:40], 64'h64);
        chk("result flags", fr.data[50:48], 64'h7);
        stall = 2'h0;
        $display("done iso result under stall");
    endtask
    task automatic t_classes();
        for (int f = 14; f <= 18; f++) begin
            i_node.send(CMD, 8'h00, 8'(f), 32'h0);
            chk("format", result_format, 64'(f - 14));
        end
        class_code = {4'hE, 4'h3, 4'h5, 4'h2, 4'h1, 4'h0};
        exp_res[0] = 64'h0001_0300_FFFE_0003;
        exp_res[1] = 64'h0C01_0300_FFFE_000C;
        for (int i = 0; i < 2; i++) begin
            i_node.send(CMD, 8'h00, 8'(15 + i), 32'h0);
            pulse_done();
            get(BASE);
            chk("class bytes", fr.data, exp_res[i]);
        end
        $display("done class results");
    endtask
    task automatic t_stop_std();
        i_node.send(CMD, 8'h00, 8'h09, 32'h0);
        chk("stop strobe", test_stop, 64'h1);
        chk("stop run", test_running, 64'h0);
        @(negedge clk);
        id_ext = 1'b0;
        base_addr = 29'h182;
        i_node.send(CMD, 8'h00, 8'h0E, 32'h0);
        chk("ext id in std mode", result_format, 64'h2);
        i_node.send(29'h202, 8'h00, 8'h0E, 32'h0);
        chk("std format", result_format, 64'h0);
        $display("done stop and std ids");
    endtask
    // ***********************
    // main sequence and watchdog
    // ***********************
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        id_ext = 1'b1;
        test_done = 1'b0;
        base_addr = BASE;
        test_time_s = 16'd1000;
        cum_count = '0;
        class_code = '0;
        status_code = 8'h5A;
        rh_pct = 8'h37;
        temp_c = 8'hF6;
        alarm_flags = 6'h2D;
        modbus_remote = 1'b1;
        start_in = 1'b1;
        relay_state = 2'b10;
        stall = 2'h0;
        n_errors = 0;
        compares = 0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        t_silent();
        t_commands();
        t_iso();
        t_classes();
        t_stop_std();
        end_sim();
    end
    initial begin
        #100000;
        n_errors++;
        $display("ERROR watchdog expected end seen timeout");
        end_sim();
    end
endmodule
`default_nettype wire
